// ### rtl/lec_link_tx_enhance.v
// Link transmit enhancement control register and AT start control
//
// Summary of operation
// - Enhancements act only with feature gate set
// - Bits 31 to 16 read zero
// - Reorder-off bit stops out-of-order AT pipelining
// - Threshold field picks FIFO start level
// - After underrun, retry uses 2K threshold
// - Start at threshold or whole packet, first
// - Drained partial packet is underrun, hold retry
// - 2K threshold waits for end-of-packet token
// - Zero retries register forces store-and-forward
// - MPEG stamp bit stamps format 20h streams
// - DV stamp bit stamps format 00h streams
// - Priority bit enables priority arbitration answers
// - Acceleration bit advertises 1394a features to PHY
// - Reserved bits read-only, return zero
// - Marked bits cleared only by global reset
// - Single-bit enables reset to zero
// - Host or EEPROM loads writable bits
// - Global reset alone clears marked bits
`timescale 1ns/1ps
`include "lec_defines.vh"

module lec_link_tx_enhance
(
    input wire mclk,
    input wire rst_b,
    input wire global_reset_n,
    input wire cfg_sel,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rvalid,
    input wire eeprom_load_valid,
    input wire [15:0] eeprom_load_data,
    input wire phy_feature_gate,
    input wire at_retries_zero,
    input wire at_pkt_queued,
    input wire [11:0] at_fifo_level,
    input wire at_pkt_checked_in,
    input wire at_fifo_empty,
    input wire at_pkt_sent,
    output reg at_tx_start,
    output reg at_underrun,
    output reg at_retry_active,
    output reg at_store_fwd,
    output reg async_tx_reorder_en,
    output reg phy_priority_arb_en,
    output reg phy_accel_notify,
    input wire iso_hdr_valid,
    input wire [5:0] iso_fmt,
    output wire iso_stamp_apply,
    output wire iso_stamp_valid
);

    localparam ST_IDLE = 3'h0;
    localparam ST_FILL = 3'h1;
    localparam ST_SEND = 3'h2;
    localparam ST_HOLD = 3'h3;
    localparam ST_RESEND = 3'h4;

    // Global-reset-only bits
    reg async_tx_reorder_off;
    reg transport_stream_stamp_on;
    reg digital_video_stamp_on;
    reg prio_arb_on;
    reg accel_on;
    // Threshold field is also reset to 1.7K by the function reset
    reg [1:0] thr_sel;

    reg [2:0] state;
    reg [2:0] next_state;
    reg next_tx_start;
    reg next_underrun;
    reg [31:0] next_rdata;

    wire soft_rst_b;
    wire reg_hit;
    wire wr_lo;
    wire wr_hi;
    wire [15:0] load_data;
    wire [15:0] load_lane;
    wire load_any;
    wire [15:0] reg_image;
    wire store_fwd_now;
    wire [11:0] thr_bytes;
    wire start_ok;
    wire rd_take;

    // Byte lanes 3:2 have no storage, so only lanes 1:0 matter
    function [15:0] lane_mask;
        input [1:0] be;
        begin
            lane_mask = {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Nominal start levels in bytes; 1.7K is taken as 1740
    function [11:0] thr_to_bytes;
        input [1:0] sel;
        begin
            case (sel)
                `LEC_THR_SEL_2K: thr_to_bytes = `LEC_THR_BYTES_2K;
                `LEC_THR_SEL_1P7K: thr_to_bytes = `LEC_THR_BYTES_1P7K;
                `LEC_THR_SEL_1K: thr_to_bytes = `LEC_THR_BYTES_1K;
                `LEC_THR_SEL_512: thr_to_bytes = `LEC_THR_BYTES_512;
                default: thr_to_bytes = `LEC_THR_BYTES_2K;
            endcase
        end
    endfunction

    // Both retry states force store-and-forward until the packet is out
    function in_retry;
        input [2:0] st;
        begin
            in_retry = (st == ST_HOLD) | (st == ST_RESEND);
        end
    endfunction

    assign soft_rst_b = rst_b & global_reset_n;
    assign reg_hit = cfg_sel & (cfg_addr == `LEC_REG_OFFSET);
    assign wr_lo = reg_hit & cfg_wr & cfg_be[0];
    assign wr_hi = reg_hit & cfg_wr & cfg_be[1];
    // One decode shared by read valid and read data
    assign rd_take = cfg_sel & cfg_rd;

    // EEPROM load takes the whole low half; it wins a same-cycle write
    assign load_any = eeprom_load_valid | wr_lo | wr_hi;
    assign load_data = eeprom_load_valid ? eeprom_load_data :
        cfg_wdata[15:0];
    assign load_lane = (eeprom_load_valid ? 16'hFFFF :
        lane_mask({wr_hi, wr_lo})) & `LEC_WRITE_MASK;

    // Function reset leaves these bits alone; only global reset clears them
    always @(posedge mclk or negedge global_reset_n)
    begin
        if (!global_reset_n)
        begin
            async_tx_reorder_off <= 1'b0;
            transport_stream_stamp_on <= 1'b0;
            digital_video_stamp_on <= 1'b0;
            prio_arb_on <= 1'b0;
            accel_on <= 1'b0;
        end
        else if (load_any)
        begin
            if (load_lane[`LEC_BIT_REORDER_OFF])
            begin
                async_tx_reorder_off <= load_data[`LEC_BIT_REORDER_OFF];
            end
            if (load_lane[`LEC_BIT_TS_STAMP])
            begin
                transport_stream_stamp_on <= load_data[`LEC_BIT_TS_STAMP];
            end
            if (load_lane[`LEC_BIT_DV_STAMP])
            begin
                digital_video_stamp_on <= load_data[`LEC_BIT_DV_STAMP];
            end
            if (load_lane[`LEC_BIT_PRIO_ARB])
            begin
                prio_arb_on <= load_data[`LEC_BIT_PRIO_ARB];
            end
            if (load_lane[`LEC_BIT_ACCEL])
            begin
                accel_on <= load_data[`LEC_BIT_ACCEL];
            end
        end
    end

    always @(posedge mclk or negedge soft_rst_b)
    begin
        if (!soft_rst_b)
        begin
            thr_sel <= `LEC_THR_RESET;
        end
        else if (load_any)
        begin
            if (load_lane[`LEC_BIT_THR_HI])
            begin
                thr_sel[1] <= load_data[`LEC_BIT_THR_HI];
            end
            if (load_lane[`LEC_BIT_THR_LO])
            begin
                thr_sel[0] <= load_data[`LEC_BIT_THR_LO];
            end
        end
    end

    // Bit 14 has no storage, so a stray write cannot reach the core
    assign reg_image = {async_tx_reorder_off, 1'b0, thr_sel,
        1'b0, transport_stream_stamp_on, 1'b0,
        digital_video_stamp_on, prio_arb_on, 5'h00,
        accel_on, 1'b0};

    always @*
    begin
        next_rdata = 32'h00000000;
        if (reg_hit)
        begin
            next_rdata = {16'h0000, reg_image};
        end
    end

    // Unmapped offsets read zero rather than stalling the bus
    always @(posedge mclk or negedge soft_rst_b)
    begin
        if (!soft_rst_b)
        begin
            cfg_rdata <= 32'h00000000;
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= rd_take;
            if (rd_take)
            begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // Gated enables toward the link core and PHY
    always @(posedge mclk or negedge soft_rst_b)
    begin
        if (!soft_rst_b)
        begin
            async_tx_reorder_en <= 1'b1;
            phy_priority_arb_en <= 1'b0;
            phy_accel_notify <= 1'b0;
        end
        else
        begin
            async_tx_reorder_en <=
                ~(phy_feature_gate & async_tx_reorder_off);
            phy_priority_arb_en <= phy_feature_gate & prio_arb_on;
            phy_accel_notify <= phy_feature_gate & accel_on;
        end
    end

    // Without the gate the threshold is not applied at all
    assign store_fwd_now = ~phy_feature_gate | at_retries_zero |
        (thr_sel == `LEC_THR_SEL_2K);
    assign thr_bytes = thr_to_bytes(thr_sel);
    assign start_ok = at_pkt_checked_in |
        (~store_fwd_now & (at_fifo_level >= thr_bytes));

    // Underrun means the FIFO drained before the whole packet arrived
    always @*
    begin
        next_state = state;
        next_tx_start = 1'b0;
        next_underrun = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (at_pkt_queued)
                begin
                    next_state = ST_FILL;
                end
            end
            ST_FILL:
            begin
                if (start_ok)
                begin
                    next_tx_start = 1'b1;
                    next_state = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (at_pkt_sent)
                begin
                    next_state = ST_IDLE;
                end
                else if (at_fifo_empty & ~at_pkt_checked_in)
                begin
                    next_underrun = 1'b1;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (at_pkt_checked_in)
                begin
                    next_tx_start = 1'b1;
                    next_state = ST_RESEND;
                end
            end
            ST_RESEND:
            begin
                if (at_pkt_sent)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Start and underrun leave as one-cycle pulses
    always @(posedge mclk or negedge soft_rst_b)
    begin
        if (!soft_rst_b)
        begin
            state <= ST_IDLE;
            at_tx_start <= 1'b0;
            at_underrun <= 1'b0;
            at_retry_active <= 1'b0;
            at_store_fwd <= 1'b1;
        end
        else
        begin
            state <= next_state;
            at_tx_start <= next_tx_start;
            at_underrun <= next_underrun;
            // Retry keeps the 2K threshold until the packet goes out
            at_retry_active <= in_retry(next_state);
            at_store_fwd <= store_fwd_now | in_retry(next_state);
        end
    end

    lec_cip_stamp u_cip_stamp
    (
        .mclk(mclk),
        .rst_b(soft_rst_b),
        .feature_gate(phy_feature_gate),
        .transport_stream_stamp_on(transport_stream_stamp_on),
        .digital_video_stamp_on(digital_video_stamp_on),
        .iso_hdr_valid(iso_hdr_valid),
        .iso_fmt(iso_fmt),
        .iso_stamp_apply(iso_stamp_apply),
        .iso_stamp_valid(iso_stamp_valid)
    );

endmodule

// ### rtl/lec_defines.vh
// Constants for the link transmit enhancement control register
`ifndef LEC_DEFINES_VH
`define LEC_DEFINES_VH

`define LEC_REG_OFFSET 8'hF4
`define LEC_RESET_VALUE 32'h00001000
`define LEC_WRITE_MASK 16'hB582
`define LEC_BIT_REORDER_OFF 15
`define LEC_BIT_RSVD_14 14
`define LEC_BIT_THR_HI 13
`define LEC_BIT_THR_LO 12
`define LEC_BIT_TS_STAMP 10
`define LEC_BIT_DV_STAMP 8
`define LEC_BIT_PRIO_ARB 7
`define LEC_BIT_ACCEL 1
`define LEC_THR_RESET 2'h1
`define LEC_THR_SEL_2K 2'h0
`define LEC_THR_SEL_1P7K 2'h1
`define LEC_THR_SEL_1K 2'h2
`define LEC_THR_SEL_512 2'h3
`define LEC_THR_BYTES_2K 12'h800
`define LEC_THR_BYTES_1P7K 12'h6CC
`define LEC_THR_BYTES_1K 12'h400
`define LEC_THR_BYTES_512 12'h200
`define LEC_FMT_MPEG 6'h20
`define LEC_FMT_DV 6'h00

`endif

// ### rtl/lec_cip_stamp.v
// Per-packet CIP timestamp enhancement selector
`timescale 1ns/1ps
`include "lec_defines.vh"

module lec_cip_stamp
(
    input wire mclk,
    input wire rst_b,
    input wire feature_gate,
    input wire transport_stream_stamp_on,
    input wire digital_video_stamp_on,
    input wire iso_hdr_valid,
    input wire [5:0] iso_fmt,
    output reg iso_stamp_apply,
    output reg iso_stamp_valid
);

    wire is_mpeg;
    wire is_dv;
    wire next_apply;

    assign is_mpeg = (iso_fmt == `LEC_FMT_MPEG);
    assign is_dv = (iso_fmt == `LEC_FMT_DV);
    // Enables only count while the feature gate is up
    assign next_apply = feature_gate &
        ((transport_stream_stamp_on & is_mpeg) |
         (digital_video_stamp_on & is_dv));

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            iso_stamp_apply <= 1'b0;
            iso_stamp_valid <= 1'b0;
        end
        else
        begin
            iso_stamp_valid <= iso_hdr_valid;
            if (iso_hdr_valid)
            begin
                iso_stamp_apply <= next_apply;
            end
        end
    end

endmodule

// ### test/lec_phy_model.sv
// PHY transmit side: ends each started packet after a delay unless it underruns
`timescale 1ns/1ps
module lec_phy_model
(
    input wire mclk,
    input wire rst_b,
    input wire slow,
    input wire at_tx_start,
    input wire at_underrun,
    output reg at_pkt_sent
);
    reg [3:0] cnt;
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= 4'h0;
            at_pkt_sent <= 1'b0;
        end
        else
        begin
            at_pkt_sent <= cnt == 4'h1;
            if (at_tx_start)
                cnt <= slow ? 4'h8 : 4'h3;
            // Underrun kills the packet on the wire, so no completion
            else if (at_underrun)
                cnt <= 4'h0;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

// ### test/lec_link_tx_enhance_checker.sv
// Port assertions for the link transmit enhancement block
`timescale 1ns/1ps
module lec_chk
(
    input wire mclk,
    input wire rst_b,
    input wire global_reset_n,
    input wire cfg_sel,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [31:0] cfg_rdata,
    input wire cfg_rvalid,
    input wire phy_feature_gate,
    input wire at_retries_zero,
    input wire at_underrun,
    input wire at_retry_active,
    input wire at_store_fwd,
    input wire async_tx_reorder_en,
    input wire phy_priority_arb_en,
    input wire phy_accel_notify,
    input wire iso_hdr_valid,
    input wire [5:0] iso_fmt,
    input wire iso_stamp_apply,
    input wire iso_stamp_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b || !global_reset_n);
    property p_hi; cfg_rvalid |-> cfg_rdata[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("upper half set");
    property p_ro; cfg_rvalid |-> (cfg_rdata & 32'h4A7D) == 0; endproperty
    a_ro: assert property (p_ro) else $error("read-only bit set");
    property p_map;
        cfg_sel && cfg_rd && cfg_addr != 8'hF4 |=> cfg_rdata == 32'h0;
    endproperty
    a_map: assert property (p_map) else $error("unmapped read");
    property p_gate;
        !phy_feature_gate |=> !phy_priority_arb_en && !phy_accel_notify;
    endproperty
    a_gate: assert property (p_gate) else $error("gate ignored");
    property p_ord; !phy_feature_gate |=> async_tx_reorder_en; endproperty
    a_ord: assert property (p_ord) else $error("reorder off");
    property p_saf; at_retries_zero |=> at_store_fwd; endproperty
    a_saf: assert property (p_saf) else $error("no store fwd");
    property p_ur; at_underrun |-> at_retry_active && at_store_fwd; endproperty
    a_ur: assert property (p_ur) else $error("underrun state");
    property p_st;
        iso_hdr_valid && !(phy_feature_gate && (iso_fmt == 6'h20 ||
        iso_fmt == 6'h00)) |=> iso_stamp_valid && !iso_stamp_apply;
    endproperty
    a_st: assert property (p_st) else $error("stamp");
endmodule
bind lec_link_tx_enhance lec_chk chk_u
(
    .mclk, .rst_b, .global_reset_n, .cfg_sel, .cfg_rd, .cfg_addr,
    .cfg_rdata, .cfg_rvalid, .phy_feature_gate, .at_retries_zero,
    .at_underrun, .at_retry_active, .at_store_fwd, .async_tx_reorder_en,
    .phy_priority_arb_en, .phy_accel_notify, .iso_hdr_valid, .iso_fmt,
    .iso_stamp_apply, .iso_stamp_valid
);

// ### test/lec_link_tx_enhance_tb.sv
// Testbench for the link transmit enhancement block
`timescale 1ns/1ps
module lec_link_tx_enhance_tb;
    logic mclk, rst_b, global_reset_n, cfg_sel, cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic eeprom_load_valid, phy_feature_gate, at_retries_zero, at_pkt_queued;
    logic [15:0] eeprom_load_data;
    logic [11:0] at_fifo_level;
    logic at_pkt_checked_in, at_fifo_empty, at_pkt_sent, at_tx_start, slow;
    logic at_underrun, at_retry_active, at_store_fwd, async_tx_reorder_en;
    logic phy_priority_arb_en, phy_accel_notify, iso_hdr_valid;
    logic [5:0] iso_fmt;
    logic iso_stamp_apply, iso_stamp_valid;
    integer error_cnt, checked, i;
    logic [11:0] thr [0:3] = '{12'h800, 12'h6CC, 12'h400, 12'h200};
    // Stamp cases: register bits, format, gate, expected apply
    logic [23:0] st [0:4] = '{{16'h0400, 6'h20, 2'b11},
        {16'h0400, 6'h00, 2'b10}, {16'h0100, 6'h00, 2'b11},
        {16'h0100, 6'h20, 2'b10}, {16'h0500, 6'h20, 2'b00}};
    lec_link_tx_enhance dut_u
    (
        .mclk, .rst_b, .global_reset_n, .cfg_sel, .cfg_wr, .cfg_rd,
        .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
        .eeprom_load_valid, .eeprom_load_data, .phy_feature_gate,
        .at_retries_zero, .at_pkt_queued, .at_fifo_level, .at_pkt_checked_in,
        .at_fifo_empty, .at_pkt_sent, .at_tx_start, .at_underrun,
        .at_retry_active, .at_store_fwd, .async_tx_reorder_en,
        .phy_priority_arb_en, .phy_accel_notify, .iso_hdr_valid, .iso_fmt,
        .iso_stamp_apply, .iso_stamp_valid
    );
    lec_phy_model phy_u
    (
        .mclk, .rst_b(rst_b & global_reset_n), .slow, .at_tx_start,
        .at_underrun, .at_pkt_sent
    );
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Write, or read and compare with d
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfg_sel <= 1'b1;
        cfg_wr <= w;
        cfg_rd <= !w;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_sel <= 1'b0;
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        repeat (4) if (!w && cfg_rvalid !== 1'b1) @(posedge mclk) #1;
        if (!w && cfg_rvalid !== 1'b1)
        begin
            error_cnt = error_cnt + 1;
            results();
        end
        if (!w) chk(cfg_rdata, d);
    endtask
    // Watch start, underrun or sent for up to n cycles
    task seen(input integer n, input integer w, input logic e);
        logic s;
        s = 1'b0;
        repeat (n) if (!s)
        begin
            @(posedge mclk);
            #1;
            s = w == 0 ? at_tx_start : w == 1 ? at_underrun : at_pkt_sent;
        end
        chk(s, e);
    endtask
    task pkt(input logic [1:0] c, input logic [11:0] l, input logic e);
        acc(1'b1, 8'hF4, {18'h0, c, 12'h000});
        @(posedge mclk);
        at_fifo_level <= l;
        at_pkt_queued <= 1'b1;
        seen(6, 0, e);
        @(posedge mclk);
        at_pkt_checked_in <= 1'b1;
        if (!e) seen(4, 0, 1'b1);
        @(posedge mclk);
        at_pkt_queued <= 1'b0;
        at_pkt_checked_in <= 1'b0;
        at_fifo_level <= 12'h000;
        seen(10, 2, 1'b1);
    endtask
    initial
    begin
        {rst_b, global_reset_n, cfg_sel, cfg_wr, cfg_rd, cfg_addr} = 0;
        {cfg_wdata, eeprom_load_valid, eeprom_load_data, iso_fmt} = 0;
        {phy_feature_gate, at_retries_zero, at_pkt_queued, slow} = 0;
        {at_fifo_level, at_pkt_checked_in, at_fifo_empty, iso_hdr_valid} = 0;
        cfg_be = 4'hF;
        error_cnt = 0;
        checked = 0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        global_reset_n <= 1'b1;
        acc(1'b0, 8'hF4, 32'h00001000);
        acc(1'b1, 8'hF4, 32'hFFFFBFFF);
        acc(1'b0, 8'hF4, 32'h0000B582);
        acc(1'b1, 8'hF8, 32'hFFFFFFFF);
        acc(1'b0, 8'hF8, 32'h00000000);
        @(posedge mclk);
        phy_feature_gate <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(phy_priority_arb_en, 1'b1);
        chk(phy_accel_notify, 1'b1);
        chk(async_tx_reorder_en, 1'b0);
        @(posedge mclk);
        rst_b <= 1'b0;
        @(posedge mclk);
        rst_b <= 1'b1;
        acc(1'b0, 8'hF4, 32'h00009582);
        @(posedge mclk);
        global_reset_n <= 1'b0;
        @(posedge mclk);
        global_reset_n <= 1'b1;
        acc(1'b0, 8'hF4, 32'h00001000);
        @(posedge mclk);
        eeprom_load_valid <= 1'b1;
        eeprom_load_data <= 16'hBFFF;
        @(posedge mclk);
        eeprom_load_valid <= 1'b0;
        acc(1'b0, 8'hF4, 32'h0000B582);
        // Lanes 3:2 store nothing; each low lane writes on its own
        @(posedge mclk);
        cfg_be <= 4'hD;
        acc(1'b1, 8'hF4, 32'h00000000);
        acc(1'b0, 8'hF4, 32'h0000B500);
        @(posedge mclk);
        cfg_be <= 4'h2;
        acc(1'b1, 8'hF4, 32'h00000000);
        acc(1'b0, 8'hF4, 32'h00000000);
        @(posedge mclk);
        cfg_be <= 4'hF;
        for (i = 0; i < 5; i = i + 1)
        begin
            acc(1'b1, 8'hF4, {16'h0, st[i][23:8]});
            @(posedge mclk);
            phy_feature_gate <= st[i][1];
            iso_fmt <= st[i][7:2];
            iso_hdr_valid <= 1'b1;
            @(posedge mclk);
            iso_hdr_valid <= 1'b0;
            #1;
            chk(iso_stamp_valid, 1'b1);
            chk(iso_stamp_apply, st[i][0]);
        end
        @(posedge mclk);
        phy_feature_gate <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            pkt(i[1:0], thr[i] - 12'h001, 1'b0);
            pkt(i[1:0], thr[i], i != 0);
        end
        acc(1'b1, 8'hF4, 32'h00003000);
        @(posedge mclk);
        at_fifo_level <= 12'h200;
        at_pkt_queued <= 1'b1;
        slow <= 1'b1;
        seen(6, 0, 1'b1);
        @(posedge mclk);
        at_fifo_empty <= 1'b1;
        seen(4, 1, 1'b1);
        chk(at_retry_active, 1'b1);
        chk(at_store_fwd, 1'b1);
        @(posedge mclk);
        at_fifo_empty <= 1'b0;
        seen(8, 0, 1'b0);
        @(posedge mclk);
        at_pkt_checked_in <= 1'b1;
        slow <= 1'b0;
        seen(4, 0, 1'b1);
        @(posedge mclk);
        at_pkt_queued <= 1'b0;
        at_pkt_checked_in <= 1'b0;
        seen(10, 2, 1'b1);
        @(posedge mclk);
        #1;
        chk(at_retry_active, 1'b0);
        chk(at_store_fwd, 1'b0);
        @(posedge mclk);
        at_retries_zero <= 1'b1;
        pkt(2'h3, 12'h200, 1'b0);
        @(posedge mclk);
        at_retries_zero <= 1'b0;
        phy_feature_gate <= 1'b0;
        pkt(2'h3, 12'h200, 1'b0);
        results();
    end
endmodule
